// file: design/mul_neg_pkg.sv
// Package for the multiply, negate and store-to-file execution datapath.
// Assumes one core clock, a synchronous reset and an APB register port.
package mul_neg_pkg;

    // Register byte offsets on the APB port.
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_WORK = 8'h04;
    localparam logic [7:0] OFS_BANK = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_PROD_LO = 8'h10;
    localparam logic [7:0] OFS_PROD_HI = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_INDEX = 8'h1c;

    // Control register bit positions.
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;

    // Instruction word fields and opcode patterns.
    localparam int ACC_BIT = 8;
    localparam logic [7:0] OPC_MUL_LIT = 8'h0d;
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;
    localparam logic [6:0] OPC_NEG = 7'h36;
    localparam logic [6:0] OPC_STORE = 7'h37;

    // Access bank split and indexed literal offset limit.
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_MAX = 8'h5f;
    localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
    localparam logic [3:0] ACCESS_HI_PAGE = 4'hf;

    // Reset values.
    localparam logic [15:0] RST_INSTR = 16'h0000;
    localparam logic [7:0] RST_WORK = 8'h00;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [4:0] RST_STATUS = 5'h00;
    localparam logic [7:0] RST_PROD = 8'h00;
    localparam logic RST_EXT = 1'b0;
    localparam logic [11:0] RST_INDEX = 12'h000;

    // Core clock period; one instruction cycle is four clocks.
    localparam int CLK_PERIOD_NS = 50;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_MUL_LIT,
        OP_MUL_FILE,
        OP_NEG,
        OP_STORE
    } op_e;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_e;

    // Status layout, low bit first: carry, digit carry, zero, overflow, negative.
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_s;

    typedef struct packed {
        logic [15:0] prod;
        logic [7:0] neg;
        flags_s nflags;
    } alu_out_s;

    function automatic op_e decode_op(input logic [15:0] ins);
        if (ins[15:8] == OPC_MUL_LIT) begin
            return OP_MUL_LIT;
        end else if (ins[15:9] == OPC_MUL_FILE) begin
            return OP_MUL_FILE;
        end else if (ins[15:9] == OPC_NEG) begin
            return OP_NEG;
        end else if (ins[15:9] == OPC_STORE) begin
            return OP_STORE;
        end
        return OP_NONE;
    endfunction

endpackage

// file: design/mul_neg_alu.sv
// Combinational multiply and negate unit with the negate flag logic.
// Assumes its operands are held stable by the caller while it is sampled.
`timescale 1ns/1ps
module mul_neg_alu
    import mul_neg_pkg::*;
(
    input wire logic [7:0] work,
    input wire logic [7:0] operand,
    output alu_out_s res
);

    always_comb begin
        res.prod = 16'(work) * 16'(operand);
        res.neg = 8'(~operand + 8'h01);
        res.nflags.n = res.neg[7];
        res.nflags.ov = (operand == 8'h80);
        res.nflags.z = (res.neg == 8'h00);
        // A digit carry out of the add only happens when the inverted low nibble is all ones.
        res.nflags.dc = (operand[3:0] == 4'h0);
        res.nflags.c = (operand == 8'h00);
    end

endmodule // mul_neg_alu

// file: design/mul_neg_exec.sv
// Execution datapath for multiply, negate and store-to-file instructions.
// Assumes an APB master and a data memory that answers reads in the same clock.
// Functional notes
// - Literal multiply opcode times working register.
// - Sixteen-bit product replaces both product registers.
// - High byte high register, low byte low.
// - Multiply keeps working and source registers.
// - Multiply leaves all status flags alone.
// - File multiply reads addressed location unsigned.
// - Access bit chooses access or selected bank.
// - Extended mode low addresses with access bit clear use indexed offset.
// - Negate computes two's complement and flags.
// - Negate writes back, working register kept.
// - Store copies working register, flags untouched.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module mul_neg_exec
    import mul_neg_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [11:0] DMEM_ADDR,
    input wire logic [7:0] DMEM_RDATA,
    output logic [7:0] DMEM_WDATA,
    output logic DMEM_WE,
    output logic BUSY
);

    logic [15:0] instr_ff;
    logic [7:0] work_ff;
    logic [3:0] bank_ff;
    flags_s status_ff;
    logic [7:0] prod_lo_ff;
    logic [7:0] prod_hi_ff;
    logic ext_ff;
    logic [11:0] index_ff;
    logic [11:0] addr_ff;
    logic [7:0] opnd_ff;
    logic [7:0] wdata_ff;
    logic we_ff;
    logic [31:0] prdata_ff;
    phase_e phase_ff;
    phase_e nxt_phase;
    op_e op;
    alu_out_s alu_res;
    logic busy;
    logic access;
    logic take;
    logic wr_take;

    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            OFS_INSTR, OFS_WORK, OFS_BANK, OFS_STATUS,
            OFS_PROD_LO, OFS_PROD_HI, OFS_CTRL, OFS_INDEX: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [11:0] resolve_addr(
        input logic [7:0] f,
        input logic acc,
        input logic ext,
        input logic [3:0] bank,
        input logic [11:0] idx
    );
        if (acc) begin
            return {bank, f};
        end else if (ext && f <= INDEX_MAX) begin
            return 12'(idx + 12'(f));
        end else if (f < ACCESS_SPLIT) begin
            return {ACCESS_LO_PAGE, f};
        end
        return {ACCESS_HI_PAGE, f};
    endfunction

    assign op = decode_op(instr_ff);
    assign busy = (phase_ff != PH_IDLE);
    assign access = PSEL && PENABLE;
    // Writes wait while an instruction runs, so software never races the write-back.
    assign PREADY = !(PWRITE && busy);
    assign PSLVERR = access && !addr_ok(PADDR);
    assign take = access && PREADY;
    assign wr_take = take && PWRITE && addr_ok(PADDR);
    assign PRDATA = prdata_ff;
    assign DMEM_ADDR = addr_ff;
    assign DMEM_WDATA = wdata_ff;
    assign DMEM_WE = we_ff;
    assign BUSY = busy;

    // operands read earlier in the cycle.
    mul_neg_alu u_alu (
        .work(work_ff),
        .operand(opnd_ff),
        .res(alu_res)
    );

    always_comb begin
        nxt_phase = phase_ff;
        case (phase_ff)
            PH_IDLE: begin
                if (wr_take && PADDR == OFS_INSTR) begin
                    nxt_phase = PH_Q1;
                end
            end
            PH_Q1: nxt_phase = PH_Q2;
            PH_Q2: nxt_phase = PH_Q3;
            PH_Q3: nxt_phase = PH_Q4;
            PH_Q4: nxt_phase = PH_IDLE;
            default: nxt_phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_ff <= PH_IDLE;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            instr_ff <= RST_INSTR;
        end else if (wr_take && PADDR == OFS_INSTR) begin
            instr_ff <= PWDATA[15:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            addr_ff <= 12'h000;
        end else if (phase_ff == PH_Q1) begin
            addr_ff <= resolve_addr(instr_ff[7:0], instr_ff[ACC_BIT], ext_ff, bank_ff, index_ff);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            opnd_ff <= 8'h00;
        end else if (phase_ff == PH_Q2) begin
            opnd_ff <= (op == OP_MUL_LIT) ? instr_ff[7:0] : DMEM_RDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            we_ff <= 1'b0;
            wdata_ff <= 8'h00;
        end else if (phase_ff == PH_Q3) begin
            we_ff <= (op == OP_NEG) || (op == OP_STORE);
            wdata_ff <= (op == OP_NEG) ? alu_res.neg : work_ff;
        end else begin
            we_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            prod_lo_ff <= RST_PROD;
            prod_hi_ff <= RST_PROD;
        end else if (phase_ff == PH_Q4 && (op == OP_MUL_LIT || op == OP_MUL_FILE)) begin
            prod_lo_ff <= alu_res.prod[7:0];
            prod_hi_ff <= alu_res.prod[15:8];
        end else if (wr_take && PADDR == OFS_PROD_LO) begin
            prod_lo_ff <= PWDATA[7:0];
        end else if (wr_take && PADDR == OFS_PROD_HI) begin
            prod_hi_ff <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            status_ff <= flags_s'(RST_STATUS);
        end else if (phase_ff == PH_Q4 && op == OP_NEG) begin
            status_ff <= alu_res.nflags;
        end else if (wr_take && PADDR == OFS_STATUS) begin
            status_ff <= flags_s'(PWDATA[4:0]);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            work_ff <= RST_WORK;
        end else if (wr_take && PADDR == OFS_WORK) begin
            work_ff <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            bank_ff <= RST_BANK;
            ext_ff <= RST_EXT;
            index_ff <= RST_INDEX;
        end else if (wr_take) begin
            if (PADDR == OFS_BANK) begin
                bank_ff <= PWDATA[3:0];
            end
            if (PADDR == OFS_CTRL) begin
                ext_ff <= PWDATA[CTRL_EXT_BIT];
            end
            if (PADDR == OFS_INDEX) begin
                index_ff <= PWDATA[11:0];
            end
        end
    end

    // Read data is caught in the setup cycle, which keeps PRDATA a flop output.
    always_ff @(posedge CLK) begin
        if (RST) begin
            prdata_ff <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                OFS_INSTR: prdata_ff <= {16'h0000, instr_ff};
                OFS_WORK: prdata_ff <= {24'h000000, work_ff};
                OFS_BANK: prdata_ff <= {28'h0000000, bank_ff};
                OFS_STATUS: prdata_ff <= {27'h0000000, status_ff};
                OFS_PROD_LO: prdata_ff <= {24'h000000, prod_lo_ff};
                OFS_PROD_HI: prdata_ff <= {24'h000000, prod_hi_ff};
                OFS_CTRL: prdata_ff <= {30'h00000000, busy, ext_ff};
                OFS_INDEX: prdata_ff <= {20'h00000, index_ff};
                default: prdata_ff <= 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    logic mul_q4;
    assign mul_q4 = (phase_ff == PH_Q4) && (op == OP_MUL_LIT || op == OP_MUL_FILE);

    a_lit_product: assert property (
        (phase_ff == PH_Q4 && op == OP_MUL_LIT) |=>
        {prod_hi_ff, prod_lo_ff} == 16'(16'($past(work_ff)) * 16'($past(instr_ff[7:0]))))
        else $error("literal product wrong");

    a_prod_pair: assert property (
        (!mul_q4 && !(wr_take && (PADDR == OFS_PROD_LO || PADDR == OFS_PROD_HI)))
        |=> $stable(prod_lo_ff) && $stable(prod_hi_ff))
        else $error("product changed without cause");

    a_prod_split: assert property (
        mul_q4 |=> prod_hi_ff == 8'((16'($past(work_ff)) * 16'($past(opnd_ff))) >> 8)
        && prod_lo_ff == 8'(16'($past(work_ff)) * 16'($past(opnd_ff))))
        else $error("product bytes misplaced");

    a_mul_keeps: assert property (
        (phase_ff == PH_Q1 && op == OP_MUL_FILE) |-> ##1 (!we_ff [*4]) and ##1 $stable(work_ff) [*4])
        else $error("multiply disturbed a source");

    a_mul_flags: assert property (
        (phase_ff == PH_Q1 && (op == OP_MUL_LIT || op == OP_MUL_FILE)) |-> ##1 $stable(status_ff) [*4])
        else $error("multiply changed status");

    a_file_operand: assert property (
        (phase_ff == PH_Q2 && op == OP_MUL_FILE) |=> opnd_ff == $past(DMEM_RDATA))
        else $error("file operand not taken");

    a_bank_select: assert property (
        (phase_ff == PH_Q2 && op != OP_MUL_LIT && instr_ff[ACC_BIT])
        |-> DMEM_ADDR == {bank_ff, instr_ff[7:0]})
        else $error("banked address wrong");

    a_indexed_addr: assert property (
        (phase_ff == PH_Q2 && op != OP_MUL_LIT && !instr_ff[ACC_BIT] && ext_ff
        && instr_ff[7:0] <= INDEX_MAX) |-> DMEM_ADDR == 12'(index_ff + 12'(instr_ff[7:0])))
        else $error("indexed address wrong");

    a_neg_flags: assert property (
        (phase_ff == PH_Q4 && op == OP_NEG) |=> status_ff.c == ($past(opnd_ff) == 8'h00)
        && status_ff.ov == ($past(opnd_ff) == 8'h80) && status_ff.z == ($past(opnd_ff) == 8'h00)
        && status_ff.dc == ($past(opnd_ff[3:0]) == 4'h0)
        && status_ff.n == $past(opnd_ff != 8'h00 && opnd_ff <= 8'h80))
        else $error("negate flags wrong");

    a_neg_write: assert property (
        (phase_ff == PH_Q4 && op == OP_NEG) |-> we_ff && wdata_ff == 8'(8'h00 - opnd_ff)
        && $stable(DMEM_ADDR) && $stable(work_ff))
        else $error("negate write-back wrong");

    a_store_work: assert property (
        (phase_ff == PH_Q4 && op == OP_STORE) |-> we_ff && wdata_ff == work_ff
        ##1 $stable(status_ff))
        else $error("store wrong");

    a_one_cycle: assert property (
        (phase_ff == PH_IDLE && nxt_phase == PH_Q1) |=> busy [*4] ##1 !busy)
        else $error("instruction not four clocks");

    a_same_cycle: assert property (
        (phase_ff == PH_Q3) |-> alu_res.prod == 16'(16'(work_ff) * 16'(opnd_ff))
        && (op != OP_MUL_LIT || opnd_ff == instr_ff[7:0]))
        else $error("result not from current operand");

    a_lit_operand: assert property (
        (phase_ff == PH_Q2 && op == OP_MUL_LIT) |=> opnd_ff == $past(instr_ff[7:0]))
        else $error("literal operand not taken");

    a_lit_no_write: assert property (
        (phase_ff == PH_Q1 && op == OP_MUL_LIT) |-> ##1 !we_ff [*4])
        else $error("literal multiply wrote memory");

    a_neg_operand: assert property (
        (phase_ff == PH_Q2 && op == OP_NEG) |=> opnd_ff == $past(DMEM_RDATA))
        else $error("negate operand not taken");

    a_access_page: assert property (
        (phase_ff == PH_Q2 && op != OP_MUL_LIT && !instr_ff[ACC_BIT]
        && !(ext_ff && instr_ff[7:0] <= INDEX_MAX)) |-> DMEM_ADDR[7:0] == instr_ff[7:0]
        && DMEM_ADDR[11:8] == ((instr_ff[7:0] < ACCESS_SPLIT) ? ACCESS_LO_PAGE : ACCESS_HI_PAGE))
        else $error("access bank address wrong");

    a_store_addr: assert property (
        (phase_ff == PH_Q4 && op == OP_STORE) |-> $stable(DMEM_ADDR) && $stable(work_ff))
        else $error("store address moved");

    a_we_only_q4: assert property (
        we_ff |-> phase_ff == PH_Q4 && (op == OP_NEG || op == OP_STORE))
        else $error("memory write outside its phase");

    a_write_stall: assert property (
        (busy && access && PWRITE) |-> !PREADY)
        else $error("write taken while busy");

    a_noop_quiet: assert property (
        (phase_ff == PH_Q4 && op == OP_NONE) |-> !we_ff ##1 $stable(status_ff) && $stable(prod_lo_ff))
        else $error("no-op changed state");

    c_lit_mul: cover property (phase_ff == PH_Q4 && op == OP_MUL_LIT);
    c_file_mul: cover property (phase_ff == PH_Q4 && op == OP_MUL_FILE);
    c_neg_zero: cover property (phase_ff == PH_Q4 && op == OP_NEG && opnd_ff == 8'h00);
    c_indexed: cover property (phase_ff == PH_Q2 && !instr_ff[ACC_BIT] && ext_ff);
    c_write_stall: cover property (busy && access && PWRITE);

endmodule // mul_neg_exec

// file: testbench/mul_negate_move_exec_tb_top.sv
// Self-checking bench for the multiply, negate and store-to-file datapath.
// Assumes the bench acts as APB master and as a zero-latency data memory.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module mul_negate_move_exec_tb_top import mul_neg_pkg::*;;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [11:0] DMEM_ADDR;
    logic [7:0] DMEM_RDATA;
    logic [7:0] DMEM_WDATA;
    logic DMEM_WE;
    logic BUSY;
    int fails = 0;
    int checks_done = 0;
    int we_cnt = 0;
    logic [7:0] mem [0:4095];
    // Corner cases first: known product pairs, negate of 80h and 00h, zero product.
    int cop [7] = '{0, 1, 2, 2, 2, 3, 0};
    logic [7:0] cw [7] = '{8'he2, 8'hc4, 8'h11, 8'h22, 8'h33, 8'h4f, 8'h00};
    logic [7:0] cv [7] = '{8'hc4, 8'hb5, 8'h3a, 8'h80, 8'h00, 8'hff, 8'h9c};

    always #(CLK_PERIOD_NS / 2) CLK = ~CLK;

    assign DMEM_RDATA = mem[DMEM_ADDR];

    always @(posedge CLK) begin
        if (DMEM_WE === 1'b1) begin
            mem[DMEM_ADDR] <= DMEM_WDATA;
            we_cnt++;
        end
    end

    mul_neg_exec i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .DMEM_ADDR(DMEM_ADDR),
        .DMEM_RDATA(DMEM_RDATA), .DMEM_WDATA(DMEM_WDATA), .DMEM_WE(DMEM_WE),
        .BUSY(BUSY));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The master never assumes a latency; only the watchdog ends a wait.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
    endtask

    task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        `CHK(nm, x, d)
    endtask

    task automatic run(input logic [15:0] ins, input int wes);
        int n;
        we_cnt = 0;
        wr_reg(OFS_INSTR, {16'h0000, ins});
        #1;
        n = 0;
        while (BUSY === 1'b1 && n < 20) begin
            @(posedge CLK);
            #1;
            n++;
        end
        `CHK("busy_clocks", 4, n)
        `CHK("mem_writes", wes, we_cnt)
    endtask

    function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f, input logic x,
        input logic [3:0] b, input logic [11:0] ix);
        if (a) return {b, f};
        if (x && f <= INDEX_MAX) return ix + {4'h0, f};
        if (f < ACCESS_SPLIT) return {ACCESS_LO_PAGE, f};
        return {ACCESS_HI_PAGE, f};
    endfunction

    initial begin
        logic [7:0] w, v, f, r, pl, ph;
        logic [3:0] b;
        logic [4:0] st, fl;
        logic [11:0] ix, ad;
        logic a, x, e;
        logic [15:0] ins, p;
        logic [31:0] d;
        int op;
        void'($urandom(19106));
        for (int j = 0; j < 4096; j++) mem[j] = 8'($urandom);
        pl = 8'h00;
        ph = 8'h00;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        for (int j = 0; j < 8; j++) expect_reg("reset_value", 8'(j * 4), 32'h0);
        apb(1'b0, 8'h20, 32'h0, d, e);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, d)
        for (int i = 0; i < 48; i++) begin
            w = 8'($urandom);
            v = 8'($urandom);
            b = 4'($urandom);
            st = 5'($urandom);
            ix = 12'($urandom);
            x = 1'($urandom);
            a = 1'($urandom);
            op = $urandom_range(0, 3);
            f = (i % 2) ? 8'($urandom_range(0, 95)) : 8'($urandom);
            if (i < 7) begin
                op = cop[i];
                w = cw[i];
                v = cv[i];
            end
            wr_reg(OFS_WORK, {24'h0, w});
            wr_reg(OFS_BANK, {28'h0, b});
            wr_reg(OFS_STATUS, {27'h0, st});
            wr_reg(OFS_CTRL, {31'h0, x});
            wr_reg(OFS_INDEX, {20'h0, ix});
            ad = eaddr(a, f, x, b, ix);
            mem[ad] = v;
            case (op)
                0: ins = {OPC_MUL_LIT, v};
                1: ins = {OPC_MUL_FILE, a, f};
                2: ins = {OPC_NEG, a, f};
                default: ins = {OPC_STORE, a, f};
            endcase
            fl = st;
            r = w;
            if (op < 2) begin
                p = {8'h00, w} * {8'h00, v};
                ph = p[15:8];
                pl = p[7:0];
                r = v;
            end else if (op == 2) begin
                r = ~v + 8'h01;
                fl = {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
            end
            run(ins, (op > 1) ? 1 : 0);
            expect_reg("work", OFS_WORK, {24'h0, w});
            expect_reg("status", OFS_STATUS, {27'h0, fl});
            expect_reg("prod_lo", OFS_PROD_LO, {24'h0, pl});
            expect_reg("prod_hi", OFS_PROD_HI, {24'h0, ph});
            `CHK("memory", r, mem[ad])
        end
        // An unknown opcode runs as a no-op; a write issued while busy must wait.
        run(16'hffff, 0);
        wr_reg(OFS_CTRL, 32'h0);
        wr_reg(OFS_INSTR, 32'h0000ffff);
        expect_reg("ctrl_busy", OFS_CTRL, 32'h00000002);
        wr_reg(OFS_INSTR, 32'h0000ffff);
        wr_reg(OFS_WORK, 32'h000000a5);
        `CHK("stall_busy", 1'b0, BUSY)
        expect_reg("stall_work", OFS_WORK, 32'h000000a5);
        print_verdict();
    end

    // The run needs under two thousand clocks; this bound is well beyond it.
    initial begin
        #(20000 * CLK_PERIOD_NS);
        fails++;
        print_verdict();
    end
endmodule // mul_negate_move_exec_tb_top
